/* rtl/edc_pkg.sv */
package edc_pkg;
  // Register map
  localparam logic [7:0] EDC_EXT_CTRL_ADDR   = 8'h18;
  localparam logic [7:0] EDC_STATUS_ADDR     = 8'h08;
  localparam logic [7:0] EDC_SPEED_CTRL_ADDR = 8'h00;

  // Field positions in the extended control register
  localparam int PIN_TWO_DIR_BIT   = 10;
  localparam int PIN_THREE_DIR_BIT = 11;
  localparam int SPEED_CHECK_BIT   = 12;
  localparam int SPEED_BYPASS_BIT  = 15;
  localparam int NO_SNOOP_DIS_BIT  = 16;
  localparam int RELAX_DIS_BIT     = 17;
  localparam int CLK_GATE_BIT      = 19;
  localparam int PHY_PD_EN_BIT     = 20;
  localparam int LINK_MODE_LSB     = 22;

  // Status and speed control field positions
  localparam int STATUS_SPEED_LSB  = 8;
  localparam int CTRL_SPEED_LSB    = 8;

  // Reset values
  localparam logic       PHY_PD_EN_RESET   = 1'h1;
  localparam logic [1:0] LINK_MODE_RESET   = 2'h0;
  localparam logic [1:0] LINK_MODE_COPPER  = 2'h0;

  // Speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Measurement window for the receive clock detector
  localparam int WINDOW_NS     = 4000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;
  // Edge counts in one window at or above which the faster speed is chosen
  localparam logic [15:0] THRESH_100  = 16'h0064;
  localparam logic [15:0] THRESH_1000 = 16'h0190;

  typedef enum logic [1:0] {
    EDC_IDLE,
    EDC_MEASURE,
    EDC_POST
  } edc_state_type;
endpackage

/* rtl/edc_speed_detect.sv */
`timescale 1ns/10ps
module edc_speed_detect #(
  parameter int WINDOW = edc_pkg::WINDOW_CYCLES
) (
  input  wire logic       core_clk,    // System clock
  input  wire logic       resetn,      // Synchronous reset, active low
  input  wire logic       start,       // Begin one measurement
  input  wire logic       rx_clk_edge, // One pulse per receive clock edge
  output logic            done,        // Result valid pulse
  output logic [1:0]      speed        // Measured speed code
);
  logic [15:0] win_cnt;
  logic [15:0] next_win_cnt;
  logic [15:0] edge_cnt;
  logic [15:0] next_edge_cnt;
  logic        busy;
  logic        next_busy;
  logic        next_done;
  logic [1:0]  next_speed;

  // Window counting and classification
  always_comb begin
    next_win_cnt  = win_cnt;
    next_edge_cnt = edge_cnt;
    next_busy     = busy;
    next_done     = 1'b0;
    next_speed    = speed;
    if (start && !busy) begin
      next_busy     = 1'b1;
      next_win_cnt  = 16'h0000;
      next_edge_cnt = 16'h0000;
    end else if (busy) begin
      if (rx_clk_edge) begin
        next_edge_cnt = edge_cnt + 16'h0001;
      end
      if (win_cnt == 16'(WINDOW - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        if (next_edge_cnt >= edc_pkg::THRESH_1000) begin
          next_speed = edc_pkg::SPEED_1000;
        end else if (next_edge_cnt >= edc_pkg::THRESH_100) begin
          next_speed = edc_pkg::SPEED_100;
        end else begin
          next_speed = edc_pkg::SPEED_10;
        end
      end else begin
        next_win_cnt = win_cnt + 16'h0001;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      win_cnt  <= 16'h0000;
      edge_cnt <= 16'h0000;
      busy     <= 1'b0;
      done     <= 1'b0;
      speed    <= edc_pkg::SPEED_10;
    end else begin
      win_cnt  <= next_win_cnt;
      edge_cnt <= next_edge_cnt;
      busy     <= next_busy;
      done     <= next_done;
      speed    <= next_speed;
    end
  end
endmodule

/* rtl/edc_attr_gate.sv */
`timescale 1ns/10ps
module edc_attr_gate (
  input  wire logic core_clk,         // System clock
  input  wire logic resetn,           // Synchronous reset, active low
  input  wire logic no_snoop_disable, // Override no-snoop off
  input  wire logic relax_disable,    // Override relaxed ordering off
  input  wire logic cfg_no_snoop_en,  // Host-bus config allows no-snoop
  input  wire logic req_no_snoop,     // Per-packet no-snoop enable
  input  wire logic host_relax_en,    // Host device control bit 4
  input  wire logic queue_relax_req,  // Per-queue and per-flow setting
  output logic      no_snoop_attr,    // No-snoop attribute to host bus
  output logic      relax_attr        // Relaxed-ordering request
);
  logic next_no_snoop_attr;
  logic next_relax_attr;

  // Attribute selection
  always_comb begin
    next_no_snoop_attr = !no_snoop_disable && cfg_no_snoop_en && req_no_snoop;
    next_relax_attr    = !relax_disable && host_relax_en && queue_relax_req;
  end

  // Registered attributes
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      no_snoop_attr <= 1'b0;
      relax_attr    <= 1'b0;
    end else begin
      no_snoop_attr <= next_no_snoop_attr;
      relax_attr    <= next_relax_attr;
    end
  end
endmodule

/* rtl/edc_top.sv */
// Functional notes
// - Bits 10 and 11 set soft pins two and three as outputs when 1, inputs when 0.
// - The pin direction bits survive software and system resets.
// - At power-on the direction bits load from the nonvolatile configuration store.
// - Writing 1 to bit 12 starts a receive clock frequency measurement; it self-clears.
// - The finished measurement is posted into the detected speed value of status.
// - With bit 15 set, detection is skipped and the control speed applies at once.
// - With bit 16 set, no packet carries the no-snoop attribute.
// - With bit 16 clear, no-snoop follows the host-bus config and per-packet enables.
// - With bit 17 set, relaxed ordering is never requested.
// - With bit 17 clear and host bit 4 set, relaxed ordering follows queue settings.
// - Bit 19 enables dynamic MAC clock gating; it loads from nonvolatile config.
// - Bit 20 permits PHY power-down and defaults to 1.
// - Link mode field 23:22 selects the interface; 00 is direct copper.
// - Link mode returns to default only on power-up or host-bus reset.
`timescale 1ns/10ps
module edc_top (
  input  wire logic        core_clk,          // 25 MHz clock
  input  wire logic        resetn,            // Power-on reset, active low
  input  wire logic        host_resetn,       // Host-bus reset, active low
  input  wire logic        soft_resetn,       // Software or system reset, active low
  input  wire logic        nvm_valid,         // Configuration store load strobe
  input  wire logic        nvm_pin_two_dir,   // Stored pin two direction
  input  wire logic        nvm_pin_three_dir, // Stored pin three direction
  input  wire logic        nvm_clk_gate,      // Stored clock gating enable
  input  wire logic        nvm_phy_pd_en,     // Stored PHY power-down enable
  input  wire logic [1:0]  nvm_link_mode,     // Stored link mode
  input  wire logic        rx_clk_edge,       // Receive clock edge pulse
  input  wire logic        cfg_no_snoop_en,   // Host-bus no-snoop enable
  input  wire logic        req_no_snoop,      // Per-packet no-snoop enable
  input  wire logic        host_relax_en,     // Host device control bit 4
  input  wire logic        queue_relax_req,   // Queue relaxed-ordering setting
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic [31:0]      prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  output logic             pin_two_oe,        // Soft pin two drives
  output logic             pin_three_oe,      // Soft pin three drives
  output logic [1:0]       link_speed,        // Speed in effect
  output logic             mac_clk_gate_en,   // Dynamic clock gating allowed
  output logic             phy_pd_allow,      // PHY low-power permitted
  output logic [1:0]       link_mode,         // Link interface select
  output logic             copper_mode,       // Direct copper interface
  output logic             no_snoop_attr,     // No-snoop attribute
  output logic             relax_attr         // Relaxed-ordering request
);
  logic        pin_two_direction;
  logic        pin_three_direction;
  logic        speed_detect_check;
  logic        speed_select_bypass;
  logic        no_snoop_disable;
  logic        relaxed_order_disable;
  logic        clk_gate;
  logic        phy_pd_en;
  logic        next_pin_two_direction;
  logic        next_pin_three_direction;
  logic        next_speed_detect_check;
  logic        next_speed_select_bypass;
  logic        next_no_snoop_disable;
  logic        next_relaxed_order_disable;
  logic        next_clk_gate;
  logic        next_phy_pd_en;
  logic [1:0]  next_link_mode;
  logic [1:0]  ctrl_speed;
  logic [1:0]  next_ctrl_speed;
  logic [1:0]  detected_speed_value;
  logic [1:0]  next_detected_speed_value;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_pin_two_oe;
  logic        next_pin_three_oe;
  logic [1:0]  next_link_speed;
  logic        next_mac_clk_gate_en;
  logic        next_phy_pd_allow;
  logic        next_copper_mode;
  logic        det_start;
  logic        det_done;
  logic [1:0]  det_speed;
  logic        wr_ctrl;
  logic        wr_speed;
  logic        access;
  logic [31:0] ctrl_word;

  // Detection of accessed word address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr[7:2] == reg_addr[7:2]);
  endfunction

  // Receive clock measurement
  edc_speed_detect #(
    .WINDOW (edc_pkg::WINDOW_CYCLES)
  ) u_detect (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .start       (det_start),
    .rx_clk_edge (rx_clk_edge),
    .done        (det_done),
    .speed       (det_speed)
  );

  // Host-bus attribute overrides
  edc_attr_gate u_attr (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .no_snoop_disable (no_snoop_disable),
    .relax_disable    (relaxed_order_disable),
    .cfg_no_snoop_en  (cfg_no_snoop_en),
    .req_no_snoop     (req_no_snoop),
    .host_relax_en    (host_relax_en),
    .queue_relax_req  (queue_relax_req),
    .no_snoop_attr    (no_snoop_attr),
    .relax_attr       (relax_attr)
  );

  // Bus decode
  always_comb begin
    access   = psel && penable && !pready;
    wr_ctrl  = access && pwrite && hit(paddr, edc_pkg::EDC_EXT_CTRL_ADDR);
    wr_speed = access && pwrite && hit(paddr, edc_pkg::EDC_SPEED_CTRL_ADDR);
    det_start = wr_ctrl && pwdata[edc_pkg::SPEED_CHECK_BIT]
                && !speed_detect_check && !speed_select_bypass;
  end

  // Readback image; reserved bits read as zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[edc_pkg::PIN_TWO_DIR_BIT]   = pin_two_direction;
    ctrl_word[edc_pkg::PIN_THREE_DIR_BIT] = pin_three_direction;
    ctrl_word[edc_pkg::SPEED_CHECK_BIT]   = speed_detect_check;
    ctrl_word[edc_pkg::SPEED_BYPASS_BIT]  = speed_select_bypass;
    ctrl_word[edc_pkg::NO_SNOOP_DIS_BIT]  = no_snoop_disable;
    ctrl_word[edc_pkg::RELAX_DIS_BIT]     = relaxed_order_disable;
    ctrl_word[edc_pkg::CLK_GATE_BIT]      = clk_gate;
    ctrl_word[edc_pkg::PHY_PD_EN_BIT]     = phy_pd_en;
    ctrl_word[edc_pkg::LINK_MODE_LSB +: 2] = link_mode;
  end

  // Register next values
  always_comb begin
    next_pin_two_direction     = pin_two_direction;
    next_pin_three_direction   = pin_three_direction;
    next_speed_detect_check    = speed_detect_check;
    next_speed_select_bypass   = speed_select_bypass;
    next_no_snoop_disable      = no_snoop_disable;
    next_relaxed_order_disable = relaxed_order_disable;
    next_clk_gate              = clk_gate;
    next_phy_pd_en             = phy_pd_en;
    next_link_mode             = link_mode;
    next_ctrl_speed            = ctrl_speed;
    next_detected_speed_value  = detected_speed_value;
    if (nvm_valid) begin
      next_pin_two_direction   = nvm_pin_two_dir;
      next_pin_three_direction = nvm_pin_three_dir;
      next_clk_gate            = nvm_clk_gate;
      next_phy_pd_en           = nvm_phy_pd_en;
      next_link_mode           = nvm_link_mode;
    end
    if (wr_ctrl) begin
      next_pin_two_direction     = pwdata[edc_pkg::PIN_TWO_DIR_BIT];
      next_pin_three_direction   = pwdata[edc_pkg::PIN_THREE_DIR_BIT];
      next_speed_select_bypass   = pwdata[edc_pkg::SPEED_BYPASS_BIT];
      next_no_snoop_disable      = pwdata[edc_pkg::NO_SNOOP_DIS_BIT];
      next_relaxed_order_disable = pwdata[edc_pkg::RELAX_DIS_BIT];
      next_clk_gate              = pwdata[edc_pkg::CLK_GATE_BIT];
      next_phy_pd_en             = pwdata[edc_pkg::PHY_PD_EN_BIT];
      next_link_mode             = pwdata[edc_pkg::LINK_MODE_LSB +: 2];
    end
    if (wr_speed) begin
      next_ctrl_speed = pwdata[edc_pkg::CTRL_SPEED_LSB +: 2];
    end
    if (det_start) begin
      next_speed_detect_check = 1'b1;
    end
    if (det_done) begin
      next_speed_detect_check   = 1'b0;
      next_detected_speed_value = det_speed;
    end
  end

  // Output and bus response next values
  always_comb begin
    next_pin_two_oe      = pin_two_direction;
    next_pin_three_oe    = pin_three_direction;
    next_link_speed      = speed_select_bypass ? ctrl_speed : detected_speed_value;
    next_mac_clk_gate_en = clk_gate;
    next_phy_pd_allow    = phy_pd_en;
    next_copper_mode     = (link_mode == edc_pkg::LINK_MODE_COPPER);
    next_pready          = access;
    next_pslverr         = 1'b0;
    next_prdata          = 32'h0000_0000;
    if (access) begin
      if (hit(paddr, edc_pkg::EDC_EXT_CTRL_ADDR)) begin
        next_prdata = ctrl_word;
      end else if (hit(paddr, edc_pkg::EDC_STATUS_ADDR)) begin
        next_prdata[edc_pkg::STATUS_SPEED_LSB +: 2] = detected_speed_value;
      end else if (hit(paddr, edc_pkg::EDC_SPEED_CTRL_ADDR)) begin
        next_prdata[edc_pkg::CTRL_SPEED_LSB +: 2] = ctrl_speed;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  // Direction bits: power-on only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_two_direction   <= 1'b0;
      pin_three_direction <= 1'b0;
    end else begin
      pin_two_direction   <= next_pin_two_direction;
      pin_three_direction <= next_pin_three_direction;
    end
  end

  // Link mode: power-on or host-bus reset
  always_ff @(posedge core_clk) begin
    if (!resetn || !host_resetn) begin
      link_mode <= edc_pkg::LINK_MODE_RESET;
    end else begin
      link_mode <= next_link_mode;
    end
  end

  // Remaining fields: power-on, host-bus or software reset
  always_ff @(posedge core_clk) begin
    if (!resetn || !host_resetn || !soft_resetn) begin
      speed_detect_check    <= 1'b0;
      speed_select_bypass   <= 1'b0;
      no_snoop_disable      <= 1'b0;
      relaxed_order_disable <= 1'b0;
      clk_gate              <= 1'b0;
      phy_pd_en             <= edc_pkg::PHY_PD_EN_RESET;
      ctrl_speed            <= edc_pkg::SPEED_10;
      detected_speed_value  <= edc_pkg::SPEED_10;
    end else begin
      speed_detect_check    <= next_speed_detect_check;
      speed_select_bypass   <= next_speed_select_bypass;
      no_snoop_disable      <= next_no_snoop_disable;
      relaxed_order_disable <= next_relaxed_order_disable;
      clk_gate              <= next_clk_gate;
      phy_pd_en             <= next_phy_pd_en;
      ctrl_speed            <= next_ctrl_speed;
      detected_speed_value  <= next_detected_speed_value;
    end
  end

  // Registered outputs and bus answer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      pin_two_oe      <= 1'b0;
      pin_three_oe    <= 1'b0;
      link_speed      <= edc_pkg::SPEED_10;
      mac_clk_gate_en <= 1'b0;
      phy_pd_allow    <= edc_pkg::PHY_PD_EN_RESET;
      copper_mode     <= 1'b1;
    end else begin
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      pin_two_oe      <= next_pin_two_oe;
      pin_three_oe    <= next_pin_three_oe;
      link_speed      <= next_link_speed;
      mac_clk_gate_en <= next_mac_clk_gate_en;
      phy_pd_allow    <= next_phy_pd_allow;
      copper_mode     <= next_copper_mode;
    end
  end
endmodule

/* tb/edc_properties.sv */
`timescale 1ns/10ps
module edc_properties (
  input wire logic        core_clk,        // Clock
  input wire logic        resetn,          // Power-on reset
  input wire logic        host_resetn,     // Host reset
  input wire logic        soft_resetn,     // Soft reset
  input wire logic        nvm_valid,       // Load strobe
  input wire logic        nvm_pin_two_dir, // Stored dir
  input wire logic        nvm_clk_gate,    // Stored gating
  input wire logic [1:0]  nvm_link_mode,   // Stored mode
  input wire logic        cfg_no_snoop_en, // Bus config
  input wire logic        req_no_snoop,    // Packet enable
  input wire logic        host_relax_en,   // Host bit 4
  input wire logic        queue_relax_req, // Queue setting
  input wire logic        psel,            // APB select
  input wire logic        penable,         // APB enable
  input wire logic        pwrite,          // APB direction
  input wire logic [7:0]  paddr,           // APB address
  input wire logic [31:0] pwdata,          // APB write data
  input wire logic [31:0] prdata,          // APB read data
  input wire logic        pready,          // APB ready
  input wire logic        pslverr,         // APB error
  input wire logic        pin_two_oe,      // Pin two drive
  input wire logic        pin_three_oe,    // Pin three drive
  input wire logic [1:0]  link_speed,      // Speed in effect
  input wire logic        mac_clk_gate_en, // Gating allowed
  input wire logic [1:0]  link_mode,       // Link mode
  input wire logic        copper_mode,     // Copper select
  input wire logic        no_snoop_attr,   // No-snoop out
  input wire logic        relax_attr       // Relaxed out
);
  logic       take;
  logic       mapped;
  logic       wr_ctrl;
  logic       all_up;
  logic [4:0] shadow;
  logic [4:0] next_shadow;

  // Bus decode
  assign take    = psel && penable && !pready;
  assign mapped  = paddr == 8'h18 || paddr == 8'h08 || paddr == 8'h00;
  assign wr_ctrl = take && pwrite && paddr == edc_pkg::EDC_EXT_CTRL_ADDR;
  assign all_up  = resetn && host_resetn && soft_resetn;

  // Shadow: control speed, bypass, no-snoop off, relaxed off
  always_comb begin
    next_shadow = shadow;
    if (wr_ctrl)
      next_shadow[2:0] = {pwdata[15], pwdata[16], pwdata[17]};
    if (take && pwrite && paddr == edc_pkg::EDC_SPEED_CTRL_ADDR)
      next_shadow[4:3] = pwdata[9:8];
    if (!host_resetn || !soft_resetn)
      next_shadow = 5'h00;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn)
      shadow <= 5'h00;
    else
      shadow <= next_shadow;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_take_bad;
    take && !mapped;
  endsequence

  chk_bus_answer : assert property (take |=> pready ##1 !pready)
    else $error("ready not one cycle after access");
  chk_bad_addr : assert property (s_take_bad |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_dir_write : assert property (wr_ctrl && !nvm_valid |-> ##2
    (pin_two_oe == $past(pwdata[10], 2) && pin_three_oe == $past(pwdata[11], 2)))
    else $error("direction outputs do not follow write");
  chk_dir_survive : assert property ((!host_resetn || !soft_resetn) &&
    !$past(wr_ctrl) && !$past(nvm_valid) |=> $stable({pin_two_oe, pin_three_oe}))
    else $error("direction changed by reset");
  chk_nvm_load : assert property (nvm_valid && !wr_ctrl && all_up |=>
    link_mode == $past(nvm_link_mode) ##1
    (pin_two_oe == $past(nvm_pin_two_dir, 2) && mac_clk_gate_en == $past(nvm_clk_gate, 2)))
    else $error("stored values not loaded");
  chk_ns_off : assert property (all_up && shadow[1] |=> !no_snoop_attr)
    else $error("no-snoop set while disabled");
  chk_ns_follow : assert property (all_up && !shadow[1] |=>
    no_snoop_attr == $past(cfg_no_snoop_en && req_no_snoop))
    else $error("no-snoop not following enables");
  chk_ro_off : assert property (all_up && shadow[0] |=> !relax_attr)
    else $error("relaxed ordering while disabled");
  chk_ro_follow : assert property (all_up && !shadow[0] |=>
    relax_attr == $past(host_relax_en && queue_relax_req))
    else $error("relaxed ordering not following queue");
  chk_bypass_speed : assert property (all_up && shadow[2] |=>
    link_speed == $past(shadow[4:3]))
    else $error("bypass speed not applied");
  chk_copper_sel : assert property ($past(resetn) |->
    copper_mode == ($past(link_mode) == edc_pkg::LINK_MODE_COPPER))
    else $error("copper select wrong");
endmodule

bind edc_top edc_properties edc_properties_i (
  .core_clk(core_clk), .resetn(resetn), .host_resetn(host_resetn),
  .soft_resetn(soft_resetn), .nvm_valid(nvm_valid), .nvm_pin_two_dir(nvm_pin_two_dir),
  .nvm_clk_gate(nvm_clk_gate), .nvm_link_mode(nvm_link_mode),
  .cfg_no_snoop_en(cfg_no_snoop_en), .req_no_snoop(req_no_snoop),
  .host_relax_en(host_relax_en), .queue_relax_req(queue_relax_req), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_two_oe(pin_two_oe), .pin_three_oe(pin_three_oe),
  .link_speed(link_speed), .mac_clk_gate_en(mac_clk_gate_en), .link_mode(link_mode),
  .copper_mode(copper_mode), .no_snoop_attr(no_snoop_attr), .relax_attr(relax_attr)
);

/* tb/edc_top_tb.sv */
`timescale 1ns/10ps
module edc_top_tb;
  localparam logic [7:0]  CTRL  = edc_pkg::EDC_EXT_CTRL_ADDR;
  localparam logic [31:0] WMASK = 32'h00db_8c00;
  localparam logic [31:0] RMASK = 32'h00db_9c00;
  logic        core_clk, resetn, host_resetn, soft_resetn, nvm_valid, rx_clk_edge;
  logic        nvm_pin_two_dir, nvm_pin_three_dir, nvm_clk_gate, nvm_phy_pd_en;
  logic        cfg_no_snoop_en, req_no_snoop, host_relax_en, queue_relax_req;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic        pin_two_oe, pin_three_oe, mac_clk_gate_en, phy_pd_allow, copper_mode;
  logic        no_snoop_attr, relax_attr;
  logic [1:0]  nvm_link_mode, link_speed, link_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int          bad_count, checks, cycles, pace;

  edc_top edc_top_i (
    .core_clk(core_clk), .resetn(resetn), .host_resetn(host_resetn),
    .soft_resetn(soft_resetn), .nvm_valid(nvm_valid), .nvm_pin_two_dir(nvm_pin_two_dir),
    .nvm_pin_three_dir(nvm_pin_three_dir), .nvm_clk_gate(nvm_clk_gate),
    .nvm_phy_pd_en(nvm_phy_pd_en), .nvm_link_mode(nvm_link_mode), .rx_clk_edge(rx_clk_edge),
    .cfg_no_snoop_en(cfg_no_snoop_en), .req_no_snoop(req_no_snoop),
    .host_relax_en(host_relax_en), .queue_relax_req(queue_relax_req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_two_oe(pin_two_oe), .pin_three_oe(pin_three_oe),
    .link_speed(link_speed), .mac_clk_gate_en(mac_clk_gate_en), .phy_pd_allow(phy_pd_allow),
    .link_mode(link_mode), .copper_mode(copper_mode), .no_snoop_attr(no_snoop_attr),
    .relax_attr(relax_attr)
  );

  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Cycle count, hang limit and receive clock pacing
  always @(posedge core_clk) begin
    cycles++;
    rx_clk_edge <= pace != 0 && cycles % pace == 0;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // Random host-bus attribute inputs
  always @(posedge core_clk)
    {cfg_no_snoop_en, req_no_snoop, host_relax_en, queue_relax_req} <= 4'($urandom);

  function automatic logic [1:0] speed_of(input int gap);
    int edges;
    edges = edc_pkg::WINDOW_CYCLES / gap;
    if (edges >= edc_pkg::THRESH_1000)
      return edc_pkg::SPEED_1000;
    if (edges >= edc_pkg::THRESH_100)
      return edc_pkg::SPEED_100;
    return edc_pkg::SPEED_10;
  endfunction

  // Fields that survive host (dirs) or soft (dirs, link mode) reset
  function automatic logic [31:0] kept(input logic [31:0] w, input logic host);
    kept = w & (host ? 32'h0000_0c00 : 32'h00c0_0c00);
  endfunction

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check("read data", e & m, rd & m);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    int n;
    {resetn, nvm_valid, rx_clk_edge, psel, penable, pwrite, paddr, pwdata} = '0;
    {host_resetn, soft_resetn} = 2'h3;
    {nvm_pin_two_dir, nvm_pin_three_dir, nvm_clk_gate, nvm_phy_pd_en, nvm_link_mode} = '0;
    {cfg_no_snoop_en, req_no_snoop, host_relax_en, queue_relax_req} = 4'h0;
    {bad_count, checks, cycles, pace} = '0;
    v = $urandom(32'ha6ee);
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk(CTRL, RMASK, 32'h0010_0000);
    check("reset outputs", 32'h3, {30'h0, phy_pd_allow, copper_mode});
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check("unmapped error", 32'h1, {31'h0, err});
    rd_chk(CTRL, RMASK, 32'h0010_0000);
    // Random control words, all-ones and all-zeros corners
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? WMASK : (i == 1) ? 32'h0 : $urandom & WMASK;
      apb(1'b1, CTRL, v);
      rd_chk(CTRL, RMASK, v);
      check("pin dirs", {30'h0, v[11:10]}, {30'h0, pin_three_oe, pin_two_oe});
      check("gate pd", {30'h0, v[20:19]}, {30'h0, phy_pd_allow, mac_clk_gate_en});
      check("link mode", {29'h0, v[23:22] == 2'h0, v[23:22]}, {29'h0, copper_mode, link_mode});
    end
    // Soft then host reset keep their fields
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, CTRL, WMASK);
      @(posedge core_clk);
      if (h != 0)
        host_resetn <= 1'b0;
      else
        soft_resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      {host_resetn, soft_resetn} <= 2'h3;
      rd_chk(CTRL, RMASK & ~32'h0018_0000, kept(WMASK, h != 0));
    end
    // Load from configuration store
    v = $urandom;
    @(posedge core_clk);
    {nvm_pin_two_dir, nvm_pin_three_dir, nvm_clk_gate, nvm_phy_pd_en, nvm_link_mode} <= v[5:0];
    nvm_valid <= 1'b1;
    @(posedge core_clk);
    nvm_valid <= 1'b0;
    rd_chk(CTRL, 32'h00d8_0c00, {8'h0, v[1:0], 1'b0, v[2], v[3], 7'h0, v[4], v[5], 10'h0});
    // Speed detection at two receive rates
    apb(1'b1, CTRL, 32'h0);
    for (int g = 1; g <= 4; g += 3) begin
      pace = g;
      apb(1'b1, CTRL, 32'h0000_1000);
      rd_chk(CTRL, 32'h0000_1000, 32'h0000_1000);
      n = 0;
      do begin
        apb(1'b0, CTRL, 32'h0);
        n++;
      end while (rd[12] !== 1'b0 && n < 60);
      check("check bit", 32'h0, rd & 32'h0000_1000);
      rd_chk(edc_pkg::EDC_STATUS_ADDR, 32'h0000_0300, {22'h0, speed_of(g), 8'h0});
      check("detected speed", {30'h0, speed_of(g)}, {30'h0, link_speed});
    end
    pace = 0;
    // Bypass applies control speed and refuses detection
    apb(1'b1, edc_pkg::EDC_SPEED_CTRL_ADDR, 32'h0000_0200);
    apb(1'b1, CTRL, 32'h0000_8000);
    apb(1'b1, CTRL, 32'h0000_9000);
    rd_chk(CTRL, 32'h0000_9000, 32'h0000_8000);
    check("bypass speed", {30'h0, edc_pkg::SPEED_1000}, {30'h0, link_speed});
    finish_test();
  end
endmodule
